/* File: hw/vts_pkg.sv */
// Operation
// - Open, close and ramp-to-goal move the setpoint at one percent per second.
// - Jump-to-goal sets the setpoint to the goal at once.
// - Finish halts an open, close or ramp-to-goal ramp and holds the setpoint; test travel is not halted.
// - Automatic testing launches a test every configured number of whole hours.
// - Every power-up restarts the automatic test interval timer from zero.
// - Auxiliary closure held 3 to 10 seconds then opened starts a test.
// - Auxiliary closure of about one second during a test aborts it.
// - The record of the latest test is kept in memory, overwriting the last.
// - Panel open, close or emergency demand cancels a running test and takes over.
// - Standard test strokes ten percent; custom stroke at most thirty, own speed and pause.
// - Test stroking speed defaults to 0.25 percent per second until configured.
// - After reaching the endpoint the valve returns to its pre-test position.
// - Green lamp flashes while test travel moves, steady once back at normal.
// - Test travel never exceeds the configured partial stroke travel limit.
// - Test or reset press during a test returns to normal at once, green steady.
// - Loop demand drives safe state, red steady, yellow off, reset ignored.
// - Loop back normal under manual reset: red and yellow steady, reset restores.
// - Panel trip: safe state, red flashes then steady, yellow on; reset restores.
// - Test relay contact switches during a test and restores when it ends.
// - Panel trip press pulses the trip relay contact for 1.5 to 3 seconds.
// - Reset press pulses the reset relay contact for 1.5 to 3 seconds.
// - Loop return follows the reset option; automatic reset needs no press.
// - Reverse-acting relay inverts the loop sense: low current normal, high trips.
// - While tripped a manual-reset flag is raised; only reset button or host leave a latched trip.
// - Tripped-by-panel flag clears only when normal and the latch timeout expired.
package vts_pkg;
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned TICK_NS = 10_000_000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   localparam int unsigned TICKS_PER_S = 1_000_000_000 / TICK_NS;
   localparam int unsigned HOUR_S = 3600;
   localparam int unsigned HOUR_TICKS = HOUR_S * TICKS_PER_S;
   localparam int unsigned HOLD_MIN_S = 3;
   localparam int unsigned HOLD_MAX_S = 10;
   localparam int unsigned ABORT_S = 1;
   localparam int unsigned PULSE_S = 2;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned RED_FLASH_S = 1;
   localparam int unsigned GREEN_FLASH_S = 1;
   localparam int unsigned HOLD_MIN_T = HOLD_MIN_S * TICKS_PER_S;
   localparam int unsigned HOLD_MAX_T = HOLD_MAX_S * TICKS_PER_S;
   localparam int unsigned ABORT_T = ABORT_S * TICKS_PER_S;
   localparam int unsigned PULSE_T = PULSE_S * TICKS_PER_S;
   localparam int unsigned FLASH_T = (FLASH_HALF_MS * 1_000_000) / TICK_NS;
   localparam int unsigned RED_FLASH_T = RED_FLASH_S * TICKS_PER_S;
   localparam int unsigned GREEN_FLASH_T = GREEN_FLASH_S * TICKS_PER_S;
   // Position unit is 0.0001 percent of ranged travel
   localparam int unsigned POS_W = 20;
   typedef logic [POS_W-1:0] vts_pos_t;
   localparam vts_pos_t POS_FULL = 20'hF_4240;
   localparam vts_pos_t RAMP_STEP = 20'h0_0064;
   localparam vts_pos_t STD_STROKE = 20'h1_86A0;
   localparam vts_pos_t MAX_STROKE = 20'h4_93E0;
   localparam logic [15:0] SPEED_RST = 16'h0019;
   localparam int unsigned REC_WORDS = 4;
   localparam logic [1:0] REC_START = 2'h0;
   localparam logic [1:0] REC_END = 2'h1;
   localparam logic [1:0] REC_RESULT = 2'h2;
   localparam logic [1:0] REC_DUR = 2'h3;
   localparam logic [7:0] RES_PASS = 8'h01;
   localparam logic [7:0] RES_ABORT = 8'h02;
   localparam logic [7:0] RES_OVERRIDE = 8'h03;
   localparam logic [7:0] RES_TRIP = 8'h04;
   localparam int unsigned PIN_AUX = 0;
   localparam int unsigned PIN_TEST = 1;
   localparam int unsigned PIN_RESET = 2;
   localparam int unsigned PIN_TRIP = 3;
   localparam int unsigned PIN_OPEN = 4;
   localparam int unsigned PIN_CLOSE = 5;
   localparam int unsigned PIN_LOOP = 6;
   localparam int unsigned PIN_N = 7;
   typedef enum logic [1:0] {TS_IDLE = 2'b00, TS_STROKE = 2'b01, TS_PAUSE = 2'b11, TS_RETURN = 2'b10} vts_test_e;
   typedef enum logic [1:0] {TR_NORMAL = 2'b00, TR_DEMAND = 2'b01, TR_READY = 2'b11, TR_RESTORE = 2'b10} vts_trip_e;
   typedef enum logic [1:0] {RO_AUTO = 2'b00, RO_MANUAL = 2'b01, RO_SMART = 2'b10} vts_reset_opt_e;
endpackage : vts_pkg

/* File: hw/vts_rec_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module vts_rec_mem (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [1:0] rd_addr,
   output logic [31:0] rd_data
);
   import vts_pkg::*;
   typedef struct packed {
      logic [REC_WORDS-1:0][31:0] word;
      logic [31:0] rd;
   } vts_mem_s;
   vts_mem_s st_q, st_d;

   always_comb begin
      st_d = st_q;
      // Record overwrite
      if (wr_en) begin
         st_d.word[wr_addr] = wr_data;
      end
      st_d.rd = st_q.word[rd_addr];
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data = st_q.rd;
endmodule : vts_rec_mem
`default_nettype wire

/* File: hw/vts_top.sv */
`timescale 1ns/1ns
`default_nettype none
module vts_top #(
   parameter int unsigned TICK_CYC_P = vts_pkg::TICK_CYC,
   parameter int unsigned HOUR_TICKS_P = vts_pkg::HOUR_TICKS
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic aux_contact,
   input wire logic btn_test,
   input wire logic btn_reset,
   input wire logic btn_trip,
   input wire logic btn_open,
   input wire logic btn_close,
   input wire logic loop_high,
   input wire logic cmd_open,
   input wire logic cmd_close,
   input wire logic ramp_to_goal_cmd,
   input wire logic jump_to_goal_cmd,
   input wire logic cmd_finish,
   input wire vts_pkg::vts_pos_t goal,
   input wire logic test_start_cmd,
   input wire logic latch_reset_cmd,
   input wire logic auto_test_en,
   input wire logic [15:0] test_interval_hr,
   input wire logic test_custom,
   input wire vts_pkg::vts_pos_t custom_stroke,
   input wire vts_pkg::vts_pos_t travel_limit,
   input wire logic speed_set,
   input wire logic [15:0] speed_val,
   input wire logic [7:0] pause_s,
   input wire logic reverse_relay,
   input wire logic [1:0] reset_option,
   input wire logic [7:0] latch_timeout_s,
   input wire logic [1:0] rec_rd_addr,
   output logic [31:0] rec_rd_data,
   output vts_pkg::vts_pos_t setpoint,
   output logic safe_state,
   output logic lamp_green,
   output logic lamp_red,
   output logic lamp_yellow,
   output logic relay_test,
   output logic relay_trip,
   output logic relay_reset,
   output logic manual_reset_req,
   output logic tripped_by_panel,
   output logic test_active
);
   import vts_pkg::*;

   typedef struct packed {
      logic [PIN_N-1:0] s1;
      logic [PIN_N-1:0] s2;
      logic [PIN_N-1:0] s3;
      logic [PIN_N-1:0] acc;
      logic [16:0] tick_cnt;
      logic [18:0] hr_ticks;
      logic [15:0] hours;
      logic [10:0] aux_cnt;
      logic aux_armed;
      logic [10:0] tst_cnt;
      logic tst_armed;
      vts_pos_t sp;
      logic ramp_on;
      vts_pos_t ramp_goal;
      vts_test_e ts;
      vts_pos_t pre_sp;
      vts_pos_t end_sp;
      logic [15:0] speed;
      logic [15:0] pause_cnt;
      logic [15:0] dur;
      vts_trip_e tr;
      logic by_panel;
      logic [6:0] red_cnt;
      logic [6:0] green_cnt;
      logic [4:0] flash_cnt;
      logic flash_ph;
      logic [7:0] trip_pulse;
      logic [7:0] reset_pulse;
      logic [6:0] latch_sub;
      logic [7:0] latch_s;
      logic [2:0] rec_left;
      logic [7:0] rec_res;
      logic o_green;
      logic o_red;
      logic o_yellow;
   } vts_state_s;

   vts_state_s st_q, st_d;
   logic [PIN_N-1:0] pins_in;
   logic mem_we;
   logic [1:0] mem_addr;
   logic [31:0] mem_data;

   assign pins_in = {loop_high, btn_close, btn_open, btn_trip, btn_reset, btn_test, aux_contact};

   always_comb begin
      logic [PIN_N-1:0] rise;
      logic [PIN_N-1:0] fall;
      logic tick;
      logic demand;
      logic start_req;
      logic btn_abort;
      logic override;
      logic done;
      logic [7:0] res;
      vts_pos_t stroke_len;
      vts_pos_t step;
      rise = '0;
      fall = '0;
      tick = 1'b0;
      demand = 1'b0;
      start_req = 1'b0;
      btn_abort = 1'b0;
      override = 1'b0;
      done = 1'b0;
      res = RES_PASS;
      stroke_len = '0;
      step = '0;
      st_d = st_q;

      // Pin synchronisers, a change counts once stages two and three agree
      st_d.s1 = pins_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < PIN_N; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.acc[i] = st_q.s2[i];
         end
      end
      rise = st_d.acc & ~st_q.acc;
      fall = ~st_d.acc & st_q.acc;

      if (st_q.tick_cnt == 17'(TICK_CYC_P - 1)) begin
         st_d.tick_cnt = '0;
         tick = 1'b1;
      end else begin
         st_d.tick_cnt = st_q.tick_cnt + 17'd1;
      end

      demand = reverse_relay ? st_q.acc[PIN_LOOP] : ~st_q.acc[PIN_LOOP];

      // Lamp flash phase
      if (tick) begin
         if (st_q.flash_cnt == 5'(FLASH_T - 1)) begin
            st_d.flash_cnt = '0;
            st_d.flash_ph = ~st_q.flash_ph;
         end else begin
            st_d.flash_cnt = st_q.flash_cnt + 5'd1;
         end
         if (st_q.trip_pulse != '0) begin
            st_d.trip_pulse = st_q.trip_pulse - 8'd1;
         end
         if (st_q.reset_pulse != '0) begin
            st_d.reset_pulse = st_q.reset_pulse - 8'd1;
         end
         if (st_q.red_cnt != '0) begin
            st_d.red_cnt = st_q.red_cnt - 7'd1;
         end
         if (st_q.aux_cnt != '1 && st_q.acc[PIN_AUX]) begin
            st_d.aux_cnt = st_q.aux_cnt + 11'd1;
         end
         if (st_q.tst_cnt != '1 && st_q.acc[PIN_TEST]) begin
            st_d.tst_cnt = st_q.tst_cnt + 11'd1;
         end
      end

      // hold window on auxiliary contact and test button
      start_req = (fall[PIN_AUX] && st_q.aux_armed && st_q.aux_cnt >= 11'(HOLD_MIN_T)
                   && st_q.aux_cnt <= 11'(HOLD_MAX_T))
               || (fall[PIN_TEST] && st_q.tst_armed && st_q.tst_cnt >= 11'(HOLD_MIN_T)
                   && st_q.tst_cnt <= 11'(HOLD_MAX_T))
               || test_start_cmd;
      if (rise[PIN_AUX]) begin
         st_d.aux_cnt = '0;
         st_d.aux_armed = (st_q.ts == TS_IDLE);
      end
      if (rise[PIN_TEST]) begin
         st_d.tst_cnt = '0;
         st_d.tst_armed = (st_q.ts == TS_IDLE);
      end

      if (tick) begin
         if (st_q.hr_ticks == 19'(HOUR_TICKS_P - 1)) begin
            st_d.hr_ticks = '0;
            if (st_q.hours != '1) begin
               st_d.hours = st_q.hours + 16'd1;
            end
         end else begin
            st_d.hr_ticks = st_q.hr_ticks + 19'd1;
         end
      end
      if (auto_test_en && test_interval_hr != '0 && st_q.hours >= test_interval_hr) begin
         start_req = 1'b1;
      end

      if (speed_set) begin
         st_d.speed = speed_val;
      end

      if (rise[PIN_TRIP]) begin
         st_d.trip_pulse = 8'(PULSE_T);
      end
      if (rise[PIN_RESET]) begin
         st_d.reset_pulse = 8'(PULSE_T);
      end

      // Trip and reset sequence
      case (st_q.tr)
         TR_NORMAL, TR_RESTORE: begin
            if (demand) begin
               st_d.tr = TR_DEMAND;
            end else if (rise[PIN_TRIP]) begin
               st_d.tr = TR_READY;
               st_d.by_panel = 1'b1;
               st_d.red_cnt = 7'(RED_FLASH_T);
            end else if (st_q.tr == TR_RESTORE && tick) begin
               if (st_q.green_cnt == '0) begin
                  st_d.tr = TR_NORMAL;
               end else begin
                  st_d.green_cnt = st_q.green_cnt - 7'd1;
               end
            end
         end
         TR_DEMAND: begin
            if (!demand) begin
               if (reset_option == RO_AUTO || (reset_option == RO_SMART && !st_q.by_panel)) begin
                  st_d.tr = TR_RESTORE;
                  st_d.green_cnt = 7'(GREEN_FLASH_T);
               end else begin
                  st_d.tr = TR_READY;
               end
            end
         end
         TR_READY: begin
            if (demand) begin
               st_d.tr = TR_DEMAND;
            end else if (rise[PIN_RESET] || latch_reset_cmd) begin
               st_d.tr = TR_RESTORE;
               st_d.green_cnt = 7'(GREEN_FLASH_T);
               st_d.red_cnt = '0;
            end
         end
         default: st_d.tr = TR_DEMAND;
      endcase

      if (st_q.tr == TR_NORMAL && st_d.tr == TR_NORMAL && st_q.by_panel) begin
         if (tick) begin
            if (st_q.latch_sub == 7'(TICKS_PER_S - 1)) begin
               st_d.latch_sub = '0;
               st_d.latch_s = st_q.latch_s + 8'd1;
            end else begin
               st_d.latch_sub = st_q.latch_sub + 7'd1;
            end
         end
         if (st_q.latch_s >= latch_timeout_s) begin
            st_d.by_panel = 1'b0;
         end
      end else begin
         st_d.latch_sub = '0;
         st_d.latch_s = '0;
      end

      btn_abort = rise[PIN_TEST] || rise[PIN_RESET];
      if (st_q.acc[PIN_AUX] && !st_q.aux_armed && st_q.aux_cnt == 11'(ABORT_T)) begin
         btn_abort = 1'b1;
      end
      override = rise[PIN_OPEN] || rise[PIN_CLOSE];

      // Partial stroke test sequence
      if (tick && st_q.ts != TS_IDLE) begin
         st_d.dur = st_q.dur + 16'd1;
      end
      case (st_q.ts)
         TS_IDLE: begin
            if (start_req && st_q.tr == TR_NORMAL && st_d.tr == TR_NORMAL && !override) begin
               stroke_len = test_custom ? ((custom_stroke > MAX_STROKE) ? MAX_STROKE : custom_stroke)
                                        : STD_STROKE;
               if (stroke_len > travel_limit) begin
                  stroke_len = travel_limit;
               end
               st_d.end_sp = (st_q.sp > stroke_len) ? st_q.sp - stroke_len : '0;
               st_d.pre_sp = st_q.sp;
               st_d.ts = TS_STROKE;
               st_d.ramp_on = 1'b0;
               st_d.dur = '0;
               st_d.hours = '0;
               st_d.hr_ticks = '0;
            end
         end
         TS_STROKE: begin
            if (tick) begin
               if (st_q.sp > st_q.end_sp + vts_pos_t'(st_q.speed)) begin
                  st_d.sp = st_q.sp - vts_pos_t'(st_q.speed);
               end else begin
                  st_d.sp = st_q.end_sp;
                  st_d.ts = TS_PAUSE;
                  st_d.pause_cnt = 16'(pause_s * TICKS_PER_S);
               end
            end
         end
         TS_PAUSE: begin
            if (tick) begin
               if (st_q.pause_cnt == '0) begin
                  st_d.ts = TS_RETURN;
               end else begin
                  st_d.pause_cnt = st_q.pause_cnt - 16'd1;
               end
            end
         end
         TS_RETURN: begin
            if (tick) begin
               if (st_q.sp + vts_pos_t'(st_q.speed) < st_q.pre_sp) begin
                  st_d.sp = st_q.sp + vts_pos_t'(st_q.speed);
               end else begin
                  st_d.sp = st_q.pre_sp;
                  done = 1'b1;
               end
            end
         end
         default: st_d.ts = TS_IDLE;
      endcase
      if (st_q.ts != TS_IDLE) begin
         if (st_d.tr != TR_NORMAL) begin
            done = 1'b1;
            res = RES_TRIP;
         end else if (override) begin
            done = 1'b1;
            res = RES_OVERRIDE;
         end else if (btn_abort) begin
            done = 1'b1;
            res = RES_ABORT;
         end
         if (done) begin
            st_d.ts = TS_IDLE;
            st_d.sp = st_q.pre_sp;
            st_d.rec_left = 3'(REC_WORDS);
            st_d.rec_res = res;
            st_d.aux_armed = 1'b0;
            st_d.tst_armed = 1'b0;
         end
      end

      // Stroking commands, only in normal operation with no test
      if (st_d.tr != TR_NORMAL) begin
         st_d.ramp_on = 1'b0;
      end else if (st_d.ts == TS_IDLE) begin
         if (cmd_open || rise[PIN_OPEN]) begin
            st_d.ramp_on = 1'b1;
            st_d.ramp_goal = POS_FULL;
         end else if (cmd_close || rise[PIN_CLOSE]) begin
            st_d.ramp_on = 1'b1;
            st_d.ramp_goal = '0;
         end else if (ramp_to_goal_cmd) begin
            st_d.ramp_on = 1'b1;
            st_d.ramp_goal = (goal > POS_FULL) ? POS_FULL : goal;
         end else if (jump_to_goal_cmd) begin
            st_d.ramp_on = 1'b0;
            st_d.sp = (goal > POS_FULL) ? POS_FULL : goal;
         end else if (cmd_finish) begin
            st_d.ramp_on = 1'b0;
         end else if (st_q.ramp_on && tick) begin
            step = (st_q.sp > st_q.ramp_goal) ? st_q.sp - st_q.ramp_goal : st_q.ramp_goal - st_q.sp;
            if (step <= RAMP_STEP) begin
               st_d.sp = st_q.ramp_goal;
               st_d.ramp_on = 1'b0;
            end else if (st_q.sp > st_q.ramp_goal) begin
               st_d.sp = st_q.sp - RAMP_STEP;
            end else begin
               st_d.sp = st_q.sp + RAMP_STEP;
            end
         end
      end

      if (st_q.rec_left != '0 && !done) begin
         st_d.rec_left = st_q.rec_left - 3'd1;
      end

      // green lamp flashes while testing or restoring
      if (st_d.tr == TR_NORMAL) begin
         st_d.o_green = (st_d.ts == TS_IDLE) ? 1'b1 : st_q.flash_ph;
      end else if (st_d.tr == TR_RESTORE) begin
         st_d.o_green = st_q.flash_ph;
      end else begin
         st_d.o_green = 1'b0;
      end
      st_d.o_red = (st_d.tr == TR_DEMAND) || (st_d.tr == TR_READY && (st_d.red_cnt == '0 || st_q.flash_ph));
      st_d.o_yellow = (st_d.tr == TR_READY);
   end

   always_comb begin
      mem_we = (st_q.rec_left != '0);
      mem_addr = 2'(REC_WORDS - 32'(st_q.rec_left));
      if (mem_addr == REC_START) begin
         mem_data = 32'(st_q.pre_sp);
      end else if (mem_addr == REC_END) begin
         mem_data = 32'(st_q.end_sp);
      end else if (mem_addr == REC_RESULT) begin
         mem_data = 32'(st_q.rec_res);
      end else begin
         mem_data = 32'(st_q.dur);
      end
   end

   // asynchronous power-on reset clears the scheduler
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.speed <= SPEED_RST;
         st_q.o_green <= 1'b1;
         // Loop pin idles high, no false demand with a normal-acting relay
         st_q.s1[PIN_LOOP] <= 1'b1;
         st_q.s2[PIN_LOOP] <= 1'b1;
         st_q.s3[PIN_LOOP] <= 1'b1;
         st_q.acc[PIN_LOOP] <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   vts_rec_mem u_rec_mem (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_en(mem_we),
      .wr_addr(mem_addr),
      .wr_data(mem_data),
      .rd_addr(rec_rd_addr),
      .rd_data(rec_rd_data)
   );

   assign setpoint = st_q.sp;
   assign safe_state = (st_q.tr == TR_DEMAND) || (st_q.tr == TR_READY);
   assign manual_reset_req = (st_q.tr == TR_DEMAND) || (st_q.tr == TR_READY);
   assign lamp_green = st_q.o_green;
   assign lamp_red = st_q.o_red;
   assign lamp_yellow = st_q.o_yellow;
   // test contact while a test runs
   assign relay_test = (st_q.ts != TS_IDLE);
   assign test_active = (st_q.ts != TS_IDLE);
   assign relay_trip = (st_q.trip_pulse != '0);
   assign relay_reset = (st_q.reset_pulse != '0);
   assign tripped_by_panel = st_q.by_panel;
endmodule : vts_top
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import vts_pkg::*;
   localparam int TC = 10;
   localparam vts_pos_t P = 20'h7_A120;
   logic clk_sys = 0, reset_n = 0, cmd_open = 0, cmd_close = 0, ramp_to_goal_cmd = 0, jump_to_goal_cmd = 0;
   logic cmd_finish = 0, test_start_cmd = 0, latch_reset_cmd = 0, auto_test_en = 0, test_custom = 0, speed_set = 0;
   logic reverse_relay = 0, safe_state, lamp_green, lamp_red, lamp_yellow, relay_test, relay_trip, relay_reset;
   logic manual_reset_req, tripped_by_panel, test_active;
   logic [15:0] test_interval_hr = 16'h0001, speed_val = 16'h03E8;
   logic [7:0] pause_s = 8'h01, latch_timeout_s = 8'h01;
   logic [1:0] reset_option = 2'h1, rec_rd_addr = 2'h0;
   vts_pos_t goal = '0, custom_stroke = MAX_STROKE, travel_limit = 20'hF_FFFF, setpoint, g;
   logic [31:0] rec_rd_data;
   logic [6:0] pins;
   logic [123:0] nq[$];
   event ev;
   int err_total = 0, checks = 0, cyc = 0;
   wire logic [61:0] obs = {rec_rd_data, setpoint, safe_state, lamp_green, lamp_red, lamp_yellow, relay_test,
      relay_trip, relay_reset, manual_reset_req, tripped_by_panel, test_active};
   always #50 clk_sys = ~clk_sys;
   vts_top #(.TICK_CYC_P(TC), .HOUR_TICKS_P(20)) vts_top_inst (.*, .aux_contact(pins[PIN_AUX]),
      .btn_test(pins[PIN_TEST]), .btn_reset(pins[PIN_RESET]), .btn_trip(pins[PIN_TRIP]),
      .btn_open(pins[PIN_OPEN]), .btn_close(pins[PIN_CLOSE]), .loop_high(pins[PIN_LOOP]));
   vts_panel vts_panel_inst (.clk_sys(clk_sys), .pins(pins));
   task automatic note(input logic [61:0] m, input logic [61:0] v);
      nq.push_back({m, v});
      ->ev;
   endtask : note
   task automatic st(input logic [9:0] m, input logic [9:0] v);
      note({52'h0, m}, {52'h0, v});
   endtask : st
   task automatic sp(input vts_pos_t v);
      note({32'h0, 20'hF_FFFF, 10'h0}, {32'h0, v, 10'h0});
   endtask : sp
   task automatic rd(input logic [1:0] a, input logic [31:0] v);
      rec_rd_addr = a;
      repeat (8) @(negedge clk_sys);
      note({32'hFFFF_FFFF, 30'h0}, {v, 30'h0});
   endtask : rd
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask : pulse
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt
   task automatic wait_test(input logic v);
      for (int i = 0; i < 5000 && test_active !== v; i++) @(negedge clk_sys);
   endtask : wait_test
   task automatic press(input int p);
      vts_panel_inst.hold(p, 1'b1, 5 * TC);
      wt(150 * TC);
   endtask : press
   task automatic summarize();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   always @(ev) begin
      logic [123:0] n;
      while (nq.size() > 0) begin
         n = nq.pop_front();
         `CHK(obs & n[123:62], n[61:0])
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      void'($urandom(32'hf46c2d69));
      wt(5);
      reset_n = 1'b1;
      note({32'h0, 30'h3FFF_FFFF}, {32'h0, 20'h0, 10'h100});
      g = P + vts_pos_t'($urandom % 65536);
      goal = g;
      pulse(jump_to_goal_cmd);
      sp(g);
      goal = g + 20'h0_00FA;
      pulse(ramp_to_goal_cmd);
      wt(4 * TC);
      sp(g + 20'h0_00FA);
      pulse(cmd_open);
      wt(3 * TC);
      pulse(cmd_finish);
      pulse(cmd_close);
      wt(3 * TC);
      pulse(cmd_finish);
      goal = P;
      pulse(jump_to_goal_cmd);
      pulse(speed_set);
      vts_panel_inst.req(PIN_AUX, TC);
      wt(6);
      st(10'h021, 10'h021);
      wt(20 * TC);
      vts_panel_inst.abort(TC);
      wt(6);
      st(10'h121, 10'h100);
      sp(P);
      rd(REC_RESULT, {24'h0, RES_ABORT});
      for (int k = 0; k < 2; k++) begin
         test_custom = (k == 0);
         travel_limit = (k == 0) ? 20'h0_C350 : 20'hF_FFFF;
         if (k == 0) vts_panel_inst.req(PIN_TEST, TC);
         else pulse(test_start_cmd);
         wait_test(1'b1);
         wait_test(1'b0);
         sp(P);
         rd(REC_END, {12'h0, (k == 0) ? P - 20'h0_C350 : P - STD_STROKE});
         rd(REC_RESULT, {24'h0, RES_PASS});
      end
      auto_test_en = 1'b1;
      wait_test(1'b1);
      auto_test_en = 1'b0;
      st(10'h001, 10'h001);
      wt(5 * TC);
      vts_panel_inst.hold(PIN_RESET, 1'b1, 5 * TC);
      wt(6);
      st(10'h101, 10'h100);
      sp(P);
      wt(250 * TC);
      vts_panel_inst.set(PIN_LOOP, 1'b0);
      wt(6);
      st(10'h2C4, 10'h284);
      press(PIN_RESET);
      st(10'h200, 10'h200);
      vts_panel_inst.set(PIN_LOOP, 1'b1);
      wt(600);
      st(10'h2C0, 10'h2C0);
      press(PIN_RESET);
      st(10'h384, 10'h100);
      press(PIN_TRIP);
      st(10'h2D2, 10'h2D2);
      press(PIN_RESET);
      st(10'h3C0, 10'h100);
      reset_option = 2'h0;
      vts_panel_inst.set(PIN_LOOP, 1'b0);
      reverse_relay = 1'b1;
      wt(6);
      st(10'h200, 10'h000);
      vts_panel_inst.set(PIN_LOOP, 1'b1);
      wt(6);
      st(10'h200, 10'h200);
      vts_panel_inst.set(PIN_LOOP, 1'b0);
      wt(150 * TC);
      st(10'h200, 10'h000);
      summarize();
   end
endmodule : testbench
bind vts_top vts_props #(.TICK_CYC_P(TICK_CYC_P)) vts_props_inst (.*);
`default_nettype wire

/* File: tb/vts_panel.sv */
`timescale 1ns/1ns
`default_nettype none
module vts_panel (
   input wire logic clk_sys,
   output logic [6:0] pins
);
   import vts_pkg::*;
   initial pins = 7'h40;
   task automatic set(input int p, input logic v);
      @(negedge clk_sys);
      pins[p] = v;
   endtask : set
   task automatic hold(input int p, input logic v, input int cyc);
      set(p, v);
      repeat (cyc) @(negedge clk_sys);
      pins[p] = ~v;
   endtask : hold
   task automatic req(input int p, input int tc);
      hold(p, 1'b1, 400 * tc);
   endtask : req
   task automatic abort(input int tc);
      hold(PIN_AUX, 1'b1, 110 * tc);
   endtask : abort
endmodule : vts_panel
`default_nettype wire

/* File: tb/vts_props.sv */
`timescale 1ns/1ns
`default_nettype none
module vts_props #(
   parameter int unsigned TICK_CYC_P = 10
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic jump_to_goal_cmd,
   input wire logic cmd_finish,
   input wire vts_pkg::vts_pos_t goal,
   input wire vts_pkg::vts_pos_t travel_limit,
   input wire vts_pkg::vts_pos_t setpoint,
   input wire logic safe_state,
   input wire logic relay_test,
   input wire logic relay_trip,
   input wire logic relay_reset,
   input wire logic manual_reset_req,
   input wire logic test_active
);
   import vts_pkg::*;
   logic [31:0] trip_q;
   logic [31:0] rst_q;
   vts_pos_t pre_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Relay pulse lengths and pre-test position
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trip_q <= '0;
         rst_q <= '0;
         pre_q <= '0;
      end else begin
         trip_q <= relay_trip ? trip_q + 1 : '0;
         rst_q <= relay_reset ? rst_q + 1 : '0;
         pre_q <= test_active ? pre_q : setpoint;
      end
   end
   property p_jump;
      jump_to_goal_cmd && !cmd_finish && !test_active && !safe_state && !manual_reset_req |=> setpoint == $past(goal);
   endproperty
   a_jump: assert property (p_jump) else $error("jump not applied");
   property p_finish;
      cmd_finish && !jump_to_goal_cmd && !test_active && !safe_state |=> $stable(setpoint);
   endproperty
   a_finish: assert property (p_finish) else $error("setpoint moved after finish");
   property p_trip_len;
      $fell(relay_trip) |-> trip_q >= 150 * TICK_CYC_P && trip_q <= 300 * TICK_CYC_P;
   endproperty
   a_trip_len: assert property (p_trip_len) else $error("trip relay pulse length");
   property p_rst_len;
      $fell(relay_reset) |-> rst_q >= 150 * TICK_CYC_P && rst_q <= 300 * TICK_CYC_P;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset relay pulse length");
   property p_override;
      safe_state |=> !test_active;
   endproperty
   a_override: assert property (p_override) else $error("test kept running in safe state");
   property p_mrr;
      $rose(safe_state) |-> ##[0:2] manual_reset_req;
   endproperty
   a_mrr: assert property (p_mrr) else $error("manual reset flag missing");
   property p_rtest;
      $rose(test_active) |-> ##[0:2] relay_test;
   endproperty
   a_rtest: assert property (p_rtest) else $error("test relay not switched");
   property p_limit;
      test_active |-> {1'b0, setpoint} + {1'b0, travel_limit} >= {1'b0, pre_q};
   endproperty
   a_limit: assert property (p_limit) else $error("test travel beyond limit");
endmodule : vts_props
`default_nettype wire
